// *** asb_cfg.svh ***
// register offsets, field positions, reset values and capacities of the sample buffer
`ifndef ASB_CFG_SVH
`define ASB_CFG_SVH
`define ASB_OFS_THRESHOLD 8'h32
`define ASB_OFS_MODE 8'h33
`define ASB_OFS_LEVEL 8'h34
`define ASB_OFS_TRIGGER 8'h35
`define ASB_OFS_FLUSH 8'h36
`define ASB_OFS_READ 8'h7f
`define ASB_BIT_ACTIVE 7
`define ASB_BIT_RES 6
`define ASB_RST_THRESHOLD 8'h00
`define ASB_RST_MODE 8'h00
`define ASB_CAP_LOW 7'h54
`define ASB_CAP_HIGH 7'h29
`define ASB_BYTES_LOW 3'h3
`define ASB_BYTES_HIGH 3'h6
`endif

// *** asb_pkg.sv ***
// types of the sample buffer
package asb_pkg;
  typedef enum logic [1:0] {
    ASB_FIFO = 2'h0,
    ASB_STREAM = 2'h1,
    ASB_TRIGGER = 2'h2,
    ASB_LIFO = 2'h3
  } asb_mode_e;
  typedef struct packed {
    logic [11:0] x;
    logic [11:0] y;
    logic [11:0] z;
  } asb_set_s;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic burst;
  } asb_reg_req_s;
endpackage

// *** asb_byte_sel.sv ***
// picks one byte of a stored set by byte index and resolution
`timescale 1ns/1ps
module asb_byte_sel
  import asb_pkg::*;
(
  input wire asb_set_s set,
  input wire logic highRes,
  input wire logic [2:0] idx,
  output logic [7:0] data
);
  always_comb begin
    data = 8'h00;
    if (highRes) begin
      // little end first: low nibble byte left aligned, then high byte
      case (idx)
        3'h0: data = {set.x[3:0], 4'h0};
        3'h1: data = set.x[11:4];
        3'h2: data = {set.y[3:0], 4'h0};
        3'h3: data = set.y[11:4];
        3'h4: data = {set.z[3:0], 4'h0};
        3'h5: data = set.z[11:4];
        default: data = 8'h00;
      endcase
    end else begin
      case (idx)
        3'h0: data = set.x[11:4];
        3'h1: data = set.y[11:4];
        3'h2: data = set.z[11:4];
        default: data = 8'h00;
      endcase
    end
  end
endmodule

// *** accel_sample_buffer.sv ***
// sample buffer of a three-axis acceleration sensor
// Operation
// - store sets only while buffer-active bit is one
// - resolution bit selects 8-bit or 12-bit stored samples
// - two-bit mode: fifo, stream, trigger, last-in-first-out
// - fifo mode fills to 84 or 41 sets, then stops storing
// - stream mode overwrites oldest set once full
// - lifo mode keeps like stream, reads newest set first
// - trigger keeps threshold sets before event, then fills until full
// - seven-bit threshold raises watermark in fifo, stream, lifo
// - level reports bytes, 6 per high and 3 per low set
// - trigger state in top bit of trigger status, rest zero
// - any write to flush register empties buffer and status, except a trigger landing in the same cycle still counts
// - no sample stored while an auto-increment buffer read runs
`timescale 1ns/1ps
`include "asb_cfg.svh"
module accel_sample_buffer
  import asb_pkg::*;
#(
  parameter int DEPTH = 84
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic sampleValid,
  input wire asb_set_s sample,
  input wire logic triggerEvent,
  input wire asb_reg_req_s regReq,
  output logic [7:0] regRdata,
  output logic watermark,
  output logic bufferFull
);
  // ring indices are seven bits wide, so the depth must fit them and hold the low-res capacity
  if (DEPTH < 84 || DEPTH > 127) begin : g_depth_check
    $error("DEPTH must be 84..127");
  end

  ////////////////////////////////////////////////////////////////////////
  localparam int AW = 7;
  typedef struct packed {
    logic [7:0] thresholdCtrl;
    logic [7:0] modeCtrl;
    logic [AW-1:0] head;
    logic [AW-1:0] count;
    logic [AW-1:0] rdSet;
    logic [2:0] rdByte;
    logic trigSeen;
    logic [7:0] rdata;
    logic watermark;
    logic full;
  } asb_state_s;
  asb_state_s st, next_st;
  asb_set_s mem [DEPTH];

  logic active, highRes, reading, store, popSet;
  asb_mode_e mode;
  logic [AW-1:0] cap, thr, wrIdx, rdIdx;
  logic [AW:0] endSum, lastSum;
  logic [7:0] selByte;
  logic [2:0] setBytes;

  assign active = st.modeCtrl[`ASB_BIT_ACTIVE];
  assign highRes = st.modeCtrl[`ASB_BIT_RES];
  assign mode = asb_mode_e'(st.modeCtrl[1:0]);
  assign cap = highRes ? `ASB_CAP_HIGH : `ASB_CAP_LOW;
  assign thr = st.thresholdCtrl[6:0];
  assign setBytes = highRes ? `ASB_BYTES_HIGH : `ASB_BYTES_LOW;
  // burst on the read port holds off storing
  assign reading = regReq.burst;
  // sums carry one extra bit: head plus count can pass 127 before wrapping
  assign endSum = {1'b0, st.head} + {1'b0, st.count};
  assign lastSum = endSum - (AW+1)'(1);
  assign wrIdx = (endSum >= (AW+1)'(DEPTH)) ? AW'(endSum - (AW+1)'(DEPTH)) : AW'(endSum);
  // newest first in lifo, oldest first otherwise
  assign rdIdx = (mode == ASB_LIFO) ?
    ((lastSum >= (AW+1)'(DEPTH)) ? AW'(lastSum - (AW+1)'(DEPTH)) : AW'(lastSum)) :
    st.head;

  asb_byte_sel byteSel (
    .set(mem[rdIdx]),
    .highRes(highRes),
    .idx(st.rdByte),
    .data(selByte)
  );

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st = st;
    store = 1'b0;
    popSet = 1'b0;
    if (active && sampleValid && !reading) begin
      case (mode)
        ASB_FIFO: store = st.count < cap;
        ASB_STREAM: store = 1'b1;
        ASB_LIFO: store = 1'b1;
        ASB_TRIGGER: store = 1'b1;
        default: store = 1'b0;
      endcase
    end
    if (store) begin
      if (mode == ASB_TRIGGER && !st.trigSeen && st.count >= thr) begin
        next_st.head = (st.head == AW'(DEPTH - 1)) ? '0 : AW'(st.head + 7'h1);
      end else if (mode == ASB_TRIGGER && st.trigSeen && st.count >= cap) begin
        store = 1'b0;
      end else if (st.count >= cap) begin
        next_st.head = (st.head == AW'(DEPTH - 1)) ? '0 : AW'(st.head + 7'h1);
      end else begin
        next_st.count = AW'(st.count + 7'h1);
      end
    end
    if (active && triggerEvent && mode == ASB_TRIGGER) begin
      next_st.trigSeen = 1'b1;
    end
    // register reads; buffer byte pops a set after its last byte
    next_st.rdata = 8'h00;
    if (regReq.rd) begin
      case (regReq.addr)
        `ASB_OFS_THRESHOLD: next_st.rdata = {1'b0, st.thresholdCtrl[6:0]};
        `ASB_OFS_MODE: next_st.rdata = {st.modeCtrl[7:6], 4'h0, st.modeCtrl[1:0]};
        `ASB_OFS_LEVEL: next_st.rdata = highRes ?
          8'(st.count * 6) : 8'(st.count * 3);
        `ASB_OFS_TRIGGER: next_st.rdata = {st.trigSeen && mode == ASB_TRIGGER, 7'h00};
        `ASB_OFS_READ: begin
          next_st.rdata = (st.count != '0) ? selByte : 8'h00;
          if (st.count != '0) begin
            if (st.rdByte == setBytes - 3'h1) begin
              next_st.rdByte = 3'h0;
              popSet = 1'b1;
            end else begin
              next_st.rdByte = st.rdByte + 3'h1;
            end
          end
        end
        default: next_st.rdata = 8'h00;
      endcase
    end
    if (popSet) begin
      if (mode != ASB_LIFO) begin
        next_st.head = (st.head == AW'(DEPTH - 1)) ? '0 : AW'(st.head + 7'h1);
      end
      next_st.count = (store && next_st.count != st.count) ? st.count : AW'(st.count - 7'h1);
    end
    if (regReq.wr) begin
      case (regReq.addr)
        `ASB_OFS_THRESHOLD: next_st.thresholdCtrl = {1'b0, regReq.wdata[6:0]};
        `ASB_OFS_MODE: next_st.modeCtrl = {regReq.wdata[7:6], 4'h0, regReq.wdata[1:0]};
        `ASB_OFS_FLUSH: begin
          next_st.head = '0;
          next_st.count = '0;
          next_st.rdByte = 3'h0;
          // a trigger landing in the flush cycle still counts
          next_st.trigSeen = active && triggerEvent && mode == ASB_TRIGGER;
          store = 1'b0;
        end
        default: ;
      endcase
    end
    next_st.watermark = active && mode != ASB_TRIGGER && thr != '0 && next_st.count >= thr;
    next_st.full = next_st.count >= cap;
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st <= '{thresholdCtrl: `ASB_RST_THRESHOLD, modeCtrl: `ASB_RST_MODE, default: '0};
    end else if (clkEn) begin
      st <= next_st;
    end
  end

  // storage has no reset; contents are only read below the count
  always_ff @(posedge core_clk) begin
    if (clkEn && store) begin
      mem[wrIdx] <= sample;
    end
  end

  assign regRdata = st.rdata;
  assign watermark = st.watermark;
  assign bufferFull = st.full;
endmodule

// *** asb_props.sv ***
// port checker of the sample buffer
`timescale 1ns/1ps
`include "asb_cfg.svh"
module asb_props
  import asb_pkg::*;
#(
  parameter int DEPTH = 84
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic sampleValid,
  input wire asb_set_s sample,
  input wire logic triggerEvent,
  input wire asb_reg_req_s regReq,
  input wire logic [7:0] regRdata,
  input wire logic watermark,
  input wire logic bufferFull
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_rd(logic [7:0] a);
    regReq.rd && clkEn && regReq.addr == a;
  endsequence
  sequence s_wr(logic [7:0] a);
    regReq.wr && clkEn && regReq.addr == a;
  endsequence
  property p_lvl_step;
    s_rd(`ASB_OFS_LEVEL) |=> regRdata % 3 == 0;
  endproperty
  property p_lvl_cap;
    s_rd(`ASB_OFS_LEVEL) |=> regRdata <= 8'hfc;
  endproperty
  property p_trig;
    s_rd(`ASB_OFS_TRIGGER) |=> regRdata[6:0] == 7'h00;
  endproperty
  // reserved bits read zero
  property p_mode;
    s_wr(`ASB_OFS_MODE) ##2 s_rd(`ASB_OFS_MODE) |=> regRdata == ($past(regReq.wdata, 3) & 8'hc3);
  endproperty
  property p_thr;
    s_wr(`ASB_OFS_THRESHOLD) ##2 s_rd(`ASB_OFS_THRESHOLD)
      |=> regRdata == ($past(regReq.wdata, 3) & 8'h7f);
  endproperty
  property p_flush_full;
    s_wr(`ASB_OFS_FLUSH) |-> ##[1:2] !bufferFull;
  endproperty
  property p_flush_wm;
    s_wr(`ASB_OFS_FLUSH) |-> ##[1:2] !watermark;
  endproperty
  // a read in progress can only empty, never fill
  property p_burst;
    regReq.burst [*3] |-> !$rose(bufferFull);
  endproperty
  a_lvl_step: assert property (p_lvl_step) else $error("level not whole bytes of sets");
  a_lvl_cap: assert property (p_lvl_cap) else $error("level above capacity");
  a_trig: assert property (p_trig) else $error("trigger status low bits set");
  a_mode: assert property (p_mode) else $error("mode readback wrong");
  a_thr: assert property (p_thr) else $error("threshold readback wrong");
  a_flush_full: assert property (p_flush_full) else $error("full after flush");
  a_flush_wm: assert property (p_flush_wm) else $error("watermark after flush");
  a_burst: assert property (p_burst) else $error("stored during burst read");
endmodule
bind accel_sample_buffer asb_props #(.DEPTH(DEPTH)) u_asb_props (.core_clk, .rst, .clkEn,
  .sampleValid, .sample, .triggerEvent, .regReq, .regRdata, .watermark, .bufferFull);

// *** asb_host.sv ***
// host model that sets up and drains the sample buffer
`timescale 1ns/1ps
`include "asb_cfg.svh"
module asb_host
  import asb_pkg::*;
(
  input wire logic core_clk,
  input wire logic [7:0] regRdata,
  output asb_reg_req_s regReq
);
  initial regReq = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regReq <= '{1'b1, 1'b0, a, d, 1'b0};
    @(posedge core_clk);
    regReq.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic b, output logic [7:0] d);
    @(posedge core_clk);
    regReq <= '{1'b0, 1'b1, a, 8'h00, b};
    @(posedge core_clk);
    regReq.rd <= 1'b0;
    // read data stands for one cycle only; take it mid-cycle
    @(negedge core_clk);
    d = regRdata;
  endtask
  task automatic rdset(input int n, output logic [7:0] q [6]);
    for (int i = 0; i < n; i++) rd(`ASB_OFS_READ, 1'b1, q[i]);
    @(posedge core_clk);
    regReq.burst <= 1'b0;
  endtask
endmodule

// *** tb_top.sv ***
// testbench of the sample buffer
`timescale 1ns/1ps
`include "asb_cfg.svh"
module tb_top
  import asb_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic clkEn = 1'b1;
  logic sampleValid = 1'b0;
  logic triggerEvent = 1'b0;
  asb_set_s sample = '0;
  asb_reg_req_s regReq;
  logic [7:0] regRdata;
  logic watermark;
  logic bufferFull;
  logic [7:0] q [6];
  logic [7:0] d;
  int nMismatch = 0;
  int checked = 0;
  always #20 core_clk = ~core_clk;
  accel_sample_buffer u_accel_sample_buffer (.core_clk, .rst, .clkEn, .sampleValid,
    .sample, .triggerEvent, .regReq, .regRdata, .watermark, .bufferFull);
  asb_host u_asb_host (.core_clk, .regRdata, .regReq);
  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      nMismatch++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic stop_test;
    $display("mismatches=%0d checks=%0d", nMismatch, checked);
    if (nMismatch == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    u_asb_host.rd(a, 1'b0, d);
    chk(e, d);
  endtask
  // x high byte carries the set number, so order shows in the first byte at low resolution and the second at high
  task automatic push(input int n, input int base);
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk);
      sampleValid <= 1'b1;
      sample <= '{12'((base + i) * 16 + 1), 12'h7f0, 12'h805};
      @(posedge core_clk);
      sampleValid <= 1'b0;
    end
    repeat (3) @(posedge core_clk);
  endtask
  initial begin
    repeat (20000) @(posedge core_clk);
    nMismatch++;
    stop_test();
  end
  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    rchk(`ASB_OFS_THRESHOLD, `ASB_RST_THRESHOLD);
    rchk(`ASB_OFS_MODE, `ASB_RST_MODE);
    push(2, 0);
    rchk(`ASB_OFS_LEVEL, 8'h00);
    u_asb_host.wr(`ASB_OFS_THRESHOLD, 8'h02);
    rchk(`ASB_OFS_THRESHOLD, 8'h02);
    u_asb_host.wr(`ASB_OFS_MODE, 8'h80);
    rchk(`ASB_OFS_MODE, 8'h80);
    push(86, 0);
    chk(8'h01, {7'h00, bufferFull});
    chk(8'h01, {7'h00, watermark});
    rchk(`ASB_OFS_LEVEL, 8'hfc);
    u_asb_host.rdset(3, q);
    chk(8'h00, q[0]);
    chk(8'h80, q[2]);
    rchk(`ASB_OFS_LEVEL, 8'hf9);
    u_asb_host.wr(`ASB_OFS_FLUSH, 8'h5a);
    rchk(`ASB_OFS_LEVEL, 8'h00);
    chk(8'h00, {7'h00, watermark});
    u_asb_host.wr(`ASB_OFS_MODE, 8'h81);
    push(86, 0);
    u_asb_host.rdset(3, q);
    chk(8'h02, q[0]);
    u_asb_host.wr(`ASB_OFS_FLUSH, 8'h00);
    u_asb_host.wr(`ASB_OFS_MODE, 8'h83);
    push(3, 16);
    u_asb_host.rdset(3, q);
    chk(8'h12, q[0]);
    u_asb_host.wr(`ASB_OFS_FLUSH, 8'hff);
    u_asb_host.wr(`ASB_OFS_MODE, 8'h82);
    push(4, 0);
    rchk(`ASB_OFS_TRIGGER, 8'h00);
    @(posedge core_clk);
    triggerEvent <= 1'b1;
    @(posedge core_clk);
    triggerEvent <= 1'b0;
    repeat (2) @(posedge core_clk);
    rchk(`ASB_OFS_TRIGGER, 8'h80);
    rchk(`ASB_OFS_LEVEL, 8'h06);
    u_asb_host.rdset(3, q);
    chk(8'h02, q[0]);
    rchk(`ASB_OFS_LEVEL, 8'h03);
    u_asb_host.wr(`ASB_OFS_FLUSH, 8'h01);
    rchk(`ASB_OFS_TRIGGER, 8'h00);
    u_asb_host.wr(`ASB_OFS_MODE, 8'hc0);
    push(1, 5);
    rchk(`ASB_OFS_LEVEL, 8'h06);
    // clock enable low freezes all state, so this set is never taken
    clkEn <= 1'b0;
    push(1, 6);
    clkEn <= 1'b1;
    rchk(`ASB_OFS_LEVEL, 8'h06);
    u_asb_host.rdset(6, q);
    chk(8'h10, q[0]);
    chk(8'h05, q[1]);
    // second reset in mid-run returns control and status to reset values
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    rchk(`ASB_OFS_MODE, `ASB_RST_MODE);
    rchk(`ASB_OFS_LEVEL, 8'h00);
    chk(8'h00, {7'h00, bufferFull});
    stop_test();
  end
endmodule
